// >>> vlf_defines.vh
// Constants for the video line fetch and attribute block
`ifndef VLF_DEFINES_VH
`define VLF_DEFINES_VH

// Register offsets (byte addresses)
`define VLF_REG_CTRL       8'h00
`define VLF_REG_STATUS     8'h04
`define VLF_REG_ULSCAN     8'h08

// Control register fields
`define VLF_CTRL_REVSCR    0
`define VLF_CTRL_BASEATTR  1
`define VLF_CTRL_BLINKFF   2
`define VLF_CTRL_DBLWIDTH  3
`define VLF_CTRL_DBLHEIGHT 4
`define VLF_CTRL_W         5
`define VLF_CTRL_RESET     5'h00

// Status register fields
`define VLF_STAT_HOLD      0
`define VLF_STAT_TERM      1
`define VLF_STAT_NSZ       2
`define VLF_STAT_BLANK     3
`define VLF_STAT_HCNT_LO   4
`define VLF_STAT_HCNT_HI   6

// Underline scan: ninth scan of the cell
`define VLF_ULSCAN_RESET   4'h8

// Character-time windows after the rise of horizontal blank
`define VLF_BND_FIRST      3'h1
`define VLF_BND_LAST       3'h2
`define VLF_GATE_FIRST     3'h1
`define VLF_GATE_LAST      3'h3
`define VLF_CLR_FIRST      3'h1
`define VLF_HCNT_MAX       3'h7
`define VLF_DBL_EXT        2

// Beam levels {high, low}
`define VLF_LVL_OFF        2'h0
`define VLF_LVL_DIM        2'h1
`define VLF_LVL_NORM       2'h2
`define VLF_LVL_BRIGHT     2'h3

// Timing: minimum dot width and clock period in ns
`define VLF_DOT_MIN_NS     80
`define VLF_CLK_NS         40

`endif

// >>> vlf_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module vlf_sync #(
  parameter W = 1
) (
  clock,
  rst,
  pin_in,
  level_out
);
  input  wire         clock;
  input  wire         rst;
  input  wire [W-1:0] pin_in;
  output reg  [W-1:0] level_out;

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  // s1_r feeds only s2_r to keep metastability out of the filter
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clock) begin
        if (rst) begin
          s1_r[i]      <= 1'b0;
          s2_r[i]      <= 1'b0;
          s3_r[i]      <= 1'b0;
          level_out[i] <= 1'b0;
        end else begin
          s1_r[i] <= pin_in[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            level_out[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

endmodule // vlf_sync

// >>> vlf_line_fetch.v
// Line fetch request timing, line end, blanking and attribute video
//
// Function
// - Address load ending a scroll-zone fetch clears the zone flag.
// - Fetch request ends on line end marker or blank, first wins.
// - Horizontal blank blanks video, clears latch, times the counter.
// - Counter after blank gives two-char boundary window, three-char gate.
// - Boundary window opens with gate, closes a char earlier, so scroll entry sets flag in time.
// - With zero scan, request rises four characters after blank rise.
// - Unterminated request drops at the next rise of horizontal blank.
// - Line end marker sampled every character edge; latch ends request.
// - After line end: blank in normal screen, dim in reverse screen.
// - Line-end latch holds itself set; only its clear resets it.
// - Latch clear starts one char after blank, held until first char.
// - Internal blanking delays the blank fall to the next character edge.
// - Double width or height ends request two characters later.
// - Attributes from four pins; base flag makes reverse pin underline.
// - Resolved attributes pass a 4-bit latch on the character edge.
// - Normal dot drives high beam output; bold drives both outputs.
// - Reverse is pin XOR screen; dim background, bold gives normal.
// - Blink on non-reversed cells drops to the next lower level.
// - Underline scan lit at cell level, or black when reversed.
// - Dot stretched by one dot time, ORed, minimum width 80 ns.
// - Zero scan of counter in use triggers a new line's fetch.
// - New-scroll-zone flag forces a fetch without zero scan.
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "vlf_defines.vh"
module vlf_line_fetch (
  clock,
  rst,
  char_clk,
  dot_clk,
  hblank,
  line_end,
  dot_in,
  attr_reverse,
  attr_underline_n,
  attr_bold_n,
  attr_blink_n,
  scan_zero,
  scroll_enter,
  scan_count,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  fetch_hold_req,
  fetch_address_load,
  vid_out
);
  input  wire        clock;
  input  wire        rst;
  input  wire        char_clk;
  input  wire        dot_clk;
  input  wire        hblank;
  input  wire        line_end;
  input  wire        dot_in;
  input  wire        attr_reverse;
  input  wire        attr_underline_n;
  input  wire        attr_bold_n;
  input  wire        attr_blink_n;
  input  wire        scan_zero;
  input  wire        scroll_enter;
  input  wire [3:0]  scan_count;
  input  wire [7:0]  reg_addr;
  input  wire [31:0] reg_wdata;
  input  wire        reg_wr;
  input  wire        reg_rd;
  output reg  [31:0] reg_rdata;
  output reg         fetch_hold_req;
  output reg         fetch_address_load;
  output reg  [1:0]  vid_out;

  // Stretch time in clock cycles, rounded up, at least one
  localparam integer DOT_MIN_CYC =
    (`VLF_DOT_MIN_NS + `VLF_CLK_NS - 1) / `VLF_CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edges

  wire [8:0] pins_s;
  wire       chclk_s;
  wire       dotclk_s;
  wire       hblank_s;
  wire       lend_s;
  wire       dot_s;
  wire       rev_s;
  wire       ul_n_s;
  wire       bold_n_s;
  wire       blink_n_s;

  vlf_sync #(
    .W (9)
  ) u_sync (
    .clock     (clock),
    .rst       (rst),
    .pin_in    ({attr_blink_n, attr_bold_n, attr_underline_n,
                 attr_reverse, dot_in, line_end, hblank, dot_clk,
                 char_clk}),
    .level_out (pins_s)
  );

  assign chclk_s   = pins_s[0];
  assign dotclk_s  = pins_s[1];
  assign hblank_s  = pins_s[2];
  assign lend_s    = pins_s[3];
  assign dot_s     = pins_s[4];
  assign rev_s     = pins_s[5];
  assign ul_n_s    = pins_s[6];
  assign bold_n_s  = pins_s[7];
  assign blink_n_s = pins_s[8];

  reg chclk_q_r;
  reg dotclk_q_r;
  reg hblank_q_r;

  wire ch_edge     = chclk_s & ~chclk_q_r;
  wire dot_edge    = dotclk_s & ~dotclk_q_r;
  wire hblank_rise = hblank_s & ~hblank_q_r;

  always @(posedge clock) begin
    if (rst) begin
      chclk_q_r  <= 1'b0;
      dotclk_q_r <= 1'b0;
      hblank_q_r <= 1'b0;
    end else begin
      chclk_q_r  <= chclk_s;
      dotclk_q_r <= dotclk_s;
      hblank_q_r <= hblank_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  reg [`VLF_CTRL_W-1:0] ctrl_r;
  reg [3:0]             ul_scan_r;

  wire rev_screen = ctrl_r[`VLF_CTRL_REVSCR];
  wire base_attr  = ctrl_r[`VLF_CTRL_BASEATTR];
  wire blink_ff   = ctrl_r[`VLF_CTRL_BLINKFF];
  wire dbl_mode   = ctrl_r[`VLF_CTRL_DBLWIDTH] | ctrl_r[`VLF_CTRL_DBLHEIGHT];

  function is_addr;
    input [7:0] a;
    input [7:0] off;
    begin
      is_addr = (a == off);
    end
  endfunction

  always @(posedge clock) begin
    if (rst) begin
      ctrl_r    <= `VLF_CTRL_RESET;
      ul_scan_r <= `VLF_ULSCAN_RESET;
    end else if (reg_wr) begin
      if (is_addr(reg_addr, `VLF_REG_CTRL)) begin
        ctrl_r <= reg_wdata[`VLF_CTRL_W-1:0];
      end
      if (is_addr(reg_addr, `VLF_REG_ULSCAN)) begin
        ul_scan_r <= reg_wdata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character counter after horizontal blank

  reg [2:0] hcnt_r;
  reg       hrun_r;

  always @(posedge clock) begin
    if (rst) begin
      hcnt_r <= 3'h0;
      hrun_r <= 1'b0;
    end else if (hblank_rise) begin
      hcnt_r <= 3'h0;
      hrun_r <= 1'b1;
    end else if (ch_edge && hrun_r) begin
      if (hcnt_r == `VLF_HCNT_MAX) begin
        hrun_r <= 1'b0;
      end else begin
        hcnt_r <= hcnt_r + 3'h1;
      end
    end
  end

  // Boundary window opens with the gate but closes a character earlier
  wire bnd_win  = hrun_r && hcnt_r >= `VLF_BND_FIRST
                         && hcnt_r <= `VLF_BND_LAST;
  wire gate_win = hrun_r && hcnt_r >= `VLF_GATE_FIRST
                         && hcnt_r <= `VLF_GATE_LAST;
  wire gate_fall = ch_edge && gate_win && hcnt_r == `VLF_GATE_LAST;
  wire gate_rise = gate_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Line-end latch and its clear window

  reg term_r;
  reg term_clr_r;

  always @(posedge clock) begin
    if (rst) begin
      term_clr_r <= 1'b0;
    end else if (!hblank_s) begin
      term_clr_r <= 1'b0;
    end else if (hrun_r && hcnt_r >= `VLF_CLR_FIRST) begin
      term_clr_r <= 1'b1;
    end
  end

  // Clear dominates as a level, like an asynchronous clear input
  always @(posedge clock) begin
    if (rst) begin
      term_r <= 1'b0;
    end else if (term_clr_r) begin
      term_r <= 1'b0;
    end else if (ch_edge) begin
      term_r <= term_r | lend_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch request generation

  reg       nsz_r;
  reg       hold_r;
  reg       hold_nsz_r;
  reg       hold_old_r;
  reg [`VLF_DBL_EXT-1:0] hold_dly_r;
  reg       hold_out_q_r;

  wire trigger  = scan_zero | nsz_r;
  wire hold_set = gate_rise && trigger && !term_r;
  wire hold_out = hold_r | (dbl_mode & hold_dly_r[`VLF_DBL_EXT-1]);
  wire ld_pulse = hold_out_q_r & ~hold_out;

  always @(posedge clock) begin
    if (rst) begin
      hold_r     <= 1'b0;
      hold_nsz_r <= 1'b0;
      hold_old_r <= 1'b0;
    end else if (hold_r && (term_r || hblank_rise)) begin
      hold_r     <= 1'b0;
      hold_old_r <= 1'b0;
    end else if (hold_r && hold_old_r && gate_fall) begin
      hold_r     <= 1'b0;
      hold_old_r <= 1'b0;
    end else if (hold_set) begin
      hold_r     <= 1'b1;
      hold_nsz_r <= nsz_r;
      hold_old_r <= 1'b0;
    end else if (hold_r && gate_fall) begin
      hold_old_r <= 1'b1;
    end
  end

  // Copy delayed by whole characters for the double-size extension
  always @(posedge clock) begin
    if (rst) begin
      hold_dly_r <= {`VLF_DBL_EXT{1'b0}};
    end else if (ch_edge) begin
      hold_dly_r <= {hold_dly_r[`VLF_DBL_EXT-2:0], hold_r};
    end
  end

  // Set wins over the clear from the address load
  always @(posedge clock) begin
    if (rst) begin
      nsz_r <= 1'b0;
    end else if (scroll_enter && bnd_win) begin
      nsz_r <= 1'b1;
    end else if (ld_pulse && hold_nsz_r) begin
      nsz_r <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      hold_out_q_r       <= 1'b0;
      fetch_hold_req     <= 1'b0;
      fetch_address_load <= 1'b0;
    end else begin
      hold_out_q_r       <= hold_out;
      fetch_hold_req     <= hold_out;
      fetch_address_load <= ld_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal blanking

  reg blank_r;

  always @(posedge clock) begin
    if (rst) begin
      blank_r <= 1'b1;
    end else if (hblank_s) begin
      blank_r <= 1'b1;
    end else if (ch_edge) begin
      blank_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Attribute resolution and latch

  // Reverse pin doubles as underline when the base flag is set
  wire a_rev   = (base_attr ? 1'b0 : rev_s) ^ rev_screen;
  wire a_ul    = ~ul_n_s | (base_attr & rev_s);
  wire a_bold  = ~bold_n_s;
  wire a_blink = ~blink_n_s;

  reg [3:0] attr_r;

  always @(posedge clock) begin
    if (rst) begin
      attr_r <= 4'h0;
    end else if (ch_edge) begin
      attr_r <= {a_blink, a_bold, a_ul, a_rev};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dot stretcher

  // Hold a new dot for the minimum width so narrow dots reach full beam
  reg       dot_d_r;
  reg [3:0] stretch_r;

  always @(posedge clock) begin
    if (rst) begin
      dot_d_r   <= 1'b0;
      stretch_r <= 4'h0;
    end else begin
      if (dot_edge) begin
        dot_d_r <= dot_s;
      end
      if (dot_s) begin
        stretch_r <= DOT_MIN_CYC[3:0];
      end else if (stretch_r != 4'h0) begin
        stretch_r <= stretch_r - 4'h1;
      end
    end
  end

  wire dot_lit = dot_s | dot_d_r | (stretch_r != 4'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Beam level

  reg [1:0] lvl;
  reg       lit;
  reg       blink_on;

  always @* begin
    lit      = dot_lit | (attr_r[1] && scan_count == ul_scan_r);
    blink_on = attr_r[3] & blink_ff;
    lvl      = `VLF_LVL_OFF;
    if (!attr_r[0]) begin
      if (lit) begin
        if (attr_r[2]) begin
          lvl = blink_on ? `VLF_LVL_NORM : `VLF_LVL_BRIGHT;
        end else begin
          lvl = blink_on ? `VLF_LVL_DIM : `VLF_LVL_NORM;
        end
      end
    end else if (!blink_on) begin
      if (!lit) begin
        lvl = attr_r[2] ? `VLF_LVL_NORM : `VLF_LVL_DIM;
      end
    end else if (lit) begin
      lvl = attr_r[2] ? `VLF_LVL_BRIGHT : `VLF_LVL_NORM;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      vid_out <= `VLF_LVL_OFF;
    end else if (blank_r) begin
      vid_out <= `VLF_LVL_OFF;
    end else if (term_r) begin
      vid_out <= rev_screen ? `VLF_LVL_DIM : `VLF_LVL_OFF;
    end else begin
      vid_out <= lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read

  always @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      reg_rdata <= 32'h0;
      if (is_addr(reg_addr, `VLF_REG_CTRL)) begin
        reg_rdata[`VLF_CTRL_W-1:0] <= ctrl_r;
      end
      if (is_addr(reg_addr, `VLF_REG_STATUS)) begin
        reg_rdata[`VLF_STAT_HOLD]  <= hold_out;
        reg_rdata[`VLF_STAT_TERM]  <= term_r;
        reg_rdata[`VLF_STAT_NSZ]   <= nsz_r;
        reg_rdata[`VLF_STAT_BLANK] <= blank_r;
        reg_rdata[`VLF_STAT_HCNT_HI:`VLF_STAT_HCNT_LO] <= hcnt_r;
      end
      if (is_addr(reg_addr, `VLF_REG_ULSCAN)) begin
        reg_rdata[3:0] <= ul_scan_r;
      end
    end else begin
      reg_rdata <= 32'h0;
    end
  end

endmodule // vlf_line_fetch

// >>> vlf_checker.sv
// Port-level assertions for the line fetch and attribute block
`timescale 1ns/10ps
module vlf_checker (
  input wire        clock,
  input wire        rst,
  input wire        char_clk,
  input wire        dot_clk,
  input wire        hblank,
  input wire        line_end,
  input wire        dot_in,
  input wire        attr_reverse,
  input wire        attr_underline_n,
  input wire        attr_bold_n,
  input wire        attr_blink_n,
  input wire        scan_zero,
  input wire        scroll_enter,
  input wire [3:0]  scan_count,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        fetch_hold_req,
  input wire        fetch_address_load,
  input wire [1:0]  vid_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  reg       chr_d_r;
  reg       hb_d_r;
  reg       scr_r;
  reg       le_r;
  reg [2:0] cnt_r;
  reg [5:0] age_r;
  ////////////////////////////////////////////////////////////////////////////
  // Character edges since blank rise; reset counts as a blank rise
  always @(posedge clock) begin
    chr_d_r <= char_clk;
    hb_d_r <= hblank;
    if (rst || (hblank && !hb_d_r))
      cnt_r <= 3'h0;
    else if (char_clk && !chr_d_r && cnt_r != 3'h7)
      cnt_r <= cnt_r + 3'h1;
    if (rst)
      scr_r <= 1'b0;
    else if (scroll_enter && cnt_r >= 3'h1 && cnt_r <= 3'h3)
      scr_r <= 1'b1;
    else if (fetch_address_load)
      scr_r <= 1'b0;
    if (rst || (hblank && !hb_d_r))
      le_r <= 1'b0;
    else if (line_end && !hblank)
      le_r <= 1'b1;
    if (!le_r)
      age_r <= 6'h0;
    else if (age_r != 6'h3f)
      age_r <= age_r + 6'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  rst_quiet_a: assert property (disable iff (1'b0)
    rst |=> !fetch_hold_req && !fetch_address_load && vid_out == 2'h0)
    else $error("outputs active after reset");
  rise_time_a: assert property (
    $rose(fetch_hold_req) |-> cnt_r >= 3'h3 && cnt_r <= 3'h5)
    else $error("request rose at wrong character");
  rise_cause_a: assert property (
    $rose(fetch_hold_req) |-> scan_zero || scr_r)
    else $error("request without zero scan or scroll");
  blank_end_a: assert property (
    $rose(hblank) |-> ##[0:60] !fetch_hold_req)
    else $error("request outlived blank");
  term_end_a: assert property (
    age_r >= 6'd40 |-> !fetch_hold_req)
    else $error("request alive after line end");
  blank_dark_a: assert property (
    hblank [*8] |-> vid_out == 2'h0)
    else $error("video lit during blank");
  load_after_a: assert property (
    $fell(fetch_hold_req) |-> ##[0:2] fetch_address_load)
    else $error("no address load at request end");
  load_once_a: assert property (
    fetch_address_load |=> !fetch_address_load)
    else $error("address load longer than a cycle");
  cover property ($rose(fetch_hold_req) && !scan_zero);
  cover property ($fell(fetch_hold_req) && le_r);
  cover property (fetch_address_load);
endmodule // vlf_checker

bind vlf_line_fetch vlf_checker u_vlf_checker (.clock(clock), .rst(rst),
  .char_clk(char_clk), .dot_clk(dot_clk), .hblank(hblank),
  .line_end(line_end), .dot_in(dot_in), .attr_reverse(attr_reverse),
  .attr_underline_n(attr_underline_n), .attr_bold_n(attr_bold_n),
  .attr_blink_n(attr_blink_n), .scan_zero(scan_zero),
  .scroll_enter(scroll_enter), .scan_count(scan_count),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .fetch_hold_req(fetch_hold_req),
  .fetch_address_load(fetch_address_load), .vid_out(vid_out));

// >>> vlf_video_model.sv
// Timing chip model: character clock, blanking and line end marker
`timescale 1ns/10ps
module vlf_video_model (
  input  wire       clock,
  input  wire       rst,
  input  wire [4:0] le_pos,
  output wire       char_clk,
  output wire       dot_clk,
  output wire       hblank,
  output wire       line_end,
  output reg  [4:0] char_idx,
  output reg  [2:0] phase
);
  reg noise_r;
  // Eight clocks a character, 24 characters a line
  assign char_clk = ~phase[2];
  assign dot_clk  = phase[0];
  // Blank ends half a character before the first visible one
  assign hblank   = (char_idx < 5'd5) ||
                    (char_idx == 5'd5 && !phase[2]);
  // Data bus is undefined in blanking and may look like markers
  assign line_end = (le_pos != 5'h0 && char_idx == le_pos) ||
                    (char_idx >= 5'd2 && char_idx <= 5'd4 && noise_r);
  always @(posedge clock) begin
    noise_r <= ^$urandom;
    if (rst) begin
      phase <= 3'h0;
      char_idx <= 5'h0;
    end else begin
      phase <= phase + 3'h1;
      if (phase == 3'h7)
        char_idx <= (char_idx == 5'd23) ? 5'h0 : char_idx + 5'h1;
    end
  end
endmodule // vlf_video_model

// >>> vlf_line_fetch_tb.sv
// Self-checking bench for the line fetch and attribute block
`timescale 1ns/10ps
`include "vlf_defines.vh"
module vlf_line_fetch_tb;
  reg         clock, rst, dot_in, a_rev, a_ul_n, a_bd_n, a_bl_n;
  reg         scan_zero, scroll_enter, reg_wr, reg_rd;
  reg  [3:0]  scan_count;
  reg  [7:0]  reg_addr;
  reg  [31:0] reg_wdata, rv;
  reg  [4:0]  le_pos;
  wire [31:0] reg_rdata;
  wire        char_clk, dot_clk, hblank, line_end, hold, ld;
  wire [1:0]  vid_out;
  wire [4:0]  ci;
  wire [2:0]  ph;
  integer     error_cnt, checks_done, len, len_l, ld_c, ld_l, nlen, i, k;
  vlf_line_fetch u_vlf_line_fetch (.clock(clock), .rst(rst),
    .char_clk(char_clk), .dot_clk(dot_clk), .hblank(hblank),
    .line_end(line_end), .dot_in(dot_in), .attr_reverse(a_rev),
    .attr_underline_n(a_ul_n), .attr_bold_n(a_bd_n), .attr_blink_n(a_bl_n),
    .scan_zero(scan_zero), .scroll_enter(scroll_enter),
    .scan_count(scan_count), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fetch_hold_req(hold), .fetch_address_load(ld), .vid_out(vid_out));
  vlf_video_model u_vlf_video_model (.clock(clock), .rst(rst),
    .le_pos(le_pos), .char_clk(char_clk), .dot_clk(dot_clk),
    .hblank(hblank), .line_end(line_end), .char_idx(ci), .phase(ph));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Per-line request length and address load count
  always @(posedge clock)
    if (ci == 5'h0 && ph == 3'h0) begin
      len_l <= len;
      len <= 0;
      ld_l <= ld_c;
      ld_c <= 0;
    end else begin
      len <= len + hold;
      ld_c <= ld_c + ld;
    end
  task chk(input [63:0] n, input [31:0] s, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("Error %0s exp %h seen %h", n, e, s);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] dd);
    begin
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= dd;
      @(posedge clock);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
    end
  endtask
  // Bounded wait for a character position, phase 2
  task sync_to(input [4:0] c);
    begin
      k = 0;
      @(posedge clock);
      while (!(ci == c && ph == 3'h2) && k < 400) begin
        @(posedge clock);
        k = k + 1;
      end
    end
  endtask
  // Beam level for a steady cell: c is {blink phase, base, reverse screen}
  function [1:0] ev(input [2:0] c, input rp, uln, bn, bln, dd, ul);
    reg       rvs, u;
    reg [1:0] fg;
    begin
      rvs = (rp & ~c[1]) ^ c[0];
      u = ul & (~uln | (rp & c[1]));
      fg = bn ? `VLF_LVL_NORM : `VLF_LVL_BRIGHT;
      if (~bln & c[2])
        fg = fg - 2'h1;
      if (rvs)
        ev = (dd | u) ? `VLF_LVL_OFF : (bn ? `VLF_LVL_DIM : `VLF_LVL_NORM);
      else
        ev = (dd | u) ? fg : `VLF_LVL_OFF;
    end
  endfunction
  task summarize;
    begin
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    // Over three and a half times the 28-odd lines of 192 clocks the tests need
    repeat (20000) @(posedge clock);
    error_cnt = error_cnt + 1;
    summarize;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, dot_in, a_ul_n, a_bd_n, a_bl_n} = 5'h1f;
    {a_rev, scan_zero, scroll_enter, reg_wr, reg_rd} = 5'h0;
    {scan_count, reg_addr, reg_wdata, le_pos} = 0;
    {error_cnt, checks_done, len, len_l, ld_c, ld_l} = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    k = $urandom(32'h877d);
    rd(8'h00);
    chk("ctrl", rv, 32'h0);
    rd(8'h08);
    chk("ulscan", rv, 32'h8);
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c);
    chk("unmap", rv, 32'h0);
    rd(8'h04);
    chk("status", rv[2:0], 3'h0);
    $display("test regs done");
    // Marker at character 12 ends the fetch and darkens the line
    scan_zero <= 1'b1;
    le_pos <= 5'd12;
    sync_to(0);
    sync_to(16);
    chk("vid_end", vid_out, `VLF_LVL_OFF);
    rd(8'h04);
    chk("latch", rv[1], 1'b1);
    sync_to(0);
    chk("fetch", len_l != 0, 1'b1);
    chk("load", ld_l, 1);
    nlen = len_l;
    for (i = 3; i < 5; i = i + 1) begin
      wr(8'h00, 32'h1 << i);
      sync_to(0);
      sync_to(0);
      chk("dbl", (len_l - nlen + 2) / 4, 4);
    end
    wr(8'h00, 32'h1);
    sync_to(0);
    sync_to(16);
    chk("vid_rev", vid_out, `VLF_LVL_DIM);
    // Marker in the first visible character must still be caught
    le_pos <= 5'd6;
    sync_to(0);
    sync_to(10);
    rd(8'h04);
    chk("first", rv[1:0], 2'h2);
    $display("test line end done");
    // Scroll entry inside and outside the boundary window
    scan_zero <= 1'b0;
    wr(8'h00, 32'h0);
    sync_to(0);
    sync_to(0);
    chk("nofetch", len_l, 0);
    sync_to(2);
    scroll_enter <= 1'b1;
    @(posedge clock);
    scroll_enter <= 1'b0;
    sync_to(0);
    chk("scroll", len_l != 0, 1'b1);
    chk("sc_load", ld_l, 1);
    sync_to(0);
    chk("cleared", len_l, 0);
    sync_to(10);
    scroll_enter <= 1'b1;
    @(posedge clock);
    scroll_enter <= 1'b0;
    sync_to(0);
    sync_to(0);
    chk("late", len_l, 0);
    $display("test scroll done");
    le_pos <= 5'h0;
    for (i = 0; i < 12; i = i + 1) begin
      rv = $urandom;
      a_rev <= rv[3];
      a_ul_n <= rv[4];
      a_bd_n <= rv[5];
      dot_in <= rv[6];
      scan_count <= rv[7] ? 4'h8 : rv[11:8];
      // Blink is only defined for cells that are not reversed
      a_bl_n <= rv[12] | ((rv[3] & ~rv[1]) ^ rv[0]);
      wr(8'h00, {29'h0, rv[2:0]});
      sync_to(0);
      sync_to(10);
      chk("attr", vid_out, ev(rv[2:0], a_rev, a_ul_n, a_bd_n, a_bl_n, dot_in,
        scan_count == 4'h8));
    end
    $display("test attributes done");
    wr(8'h00, 32'h0);
    {a_rev, a_ul_n, a_bd_n, a_bl_n, dot_in} <= 5'h0e;
    sync_to(0);
    sync_to(10);
    dot_in <= 1'b1;
    k = 0;
    for (i = 0; i < 14; i = i + 1) begin
      @(posedge clock);
      if (i == 1)
        dot_in <= 1'b0;
      k = k + (vid_out == `VLF_LVL_NORM);
    end
    chk("stretch", k >= 3, 1'b1);
    $display("test dot stretch done");
    // Reset lands while a fetch is running
    scan_zero <= 1'b1;
    le_pos <= 5'd12;
    sync_to(0);
    sync_to(8);
    chk("pre", hold, 1'b1);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    chk("rst_hold", {hold, ld, vid_out}, 4'h0);
    rst <= 1'b0;
    rd(8'h00);
    chk("rst_ctrl", rv, 32'h0);
    $display("test reset done");
    summarize;
  end
endmodule // vlf_line_fetch_tb
